/* File: dual_serial_config_port_params.svh */
// Purpose: constants for the dual serial configuration port
// Assumes: 8-bit register addresses, page byte forms the upper address half
// Notes: offsets are full 16-bit map addresses {page, low byte}
`ifndef DUAL_SERIAL_CONFIG_PORT_PARAMS_SVH
`define DUAL_SERIAL_CONFIG_PORT_PARAMS_SVH

// register map
`define PAGE_SEL_LOW   8'h01
`define WIRE_CFG_OFS   16'h002b
`define IO_CFG_OFS     16'h0943
`define WIRE_SEL_BIT   3
`define IO_SEL_BIT     0

// reset values: 4-wire spi, core-supply threshold, page zero
`define PAGE_SEL_RST   8'h00
`define WIRE_CFG_RST   8'h00
`define IO_CFG_RST     8'h00

// i2c: upper five address bits, value is arbitrary
`define I2C_ADDR_HI    5'h0a
`define I2C_BYTE_BITS  4'h8

// spi command codes, top three bits of the command byte; burst is a whole command byte
`define CMD_SET_ADDR   3'h0
`define CMD_WR         3'h2
`define CMD_WR_INC     3'h3
`define CMD_RD         3'h4
`define CMD_RD_INC     3'h5
`define CMD_BURST      8'he0

// byte shifted out when the fetch handshake has not completed
`define RD_NOT_READY   8'h00

`endif

/* File: serial_port_pkg.sv */
// Purpose: types for the dual serial configuration port
// Assumes: one-hot state codes
// Notes: each clock domain owns its own state struct
package serial_port_pkg;

	typedef enum logic [6:0] {
		SPI_CMD   = 7'h01,
		SPI_ADDR  = 7'h02,
		SPI_WDATA = 7'h04,
		SPI_RDATA = 7'h08,
		SPI_BADDR = 7'h10,
		SPI_BDATA = 7'h20,
		SPI_SKIP  = 7'h40
	} spi_st_t;

	typedef enum logic [6:0] {
		I2C_IDLE = 7'h01,
		I2C_ADDR = 7'h02,
		I2C_REG  = 7'h04,
		I2C_WR   = 7'h08,
		I2C_RD   = 7'h10,
		I2C_ACK  = 7'h20,
		I2C_MACK = 7'h40
	} i2c_st_t;

	// core clock domain: registers, i2c slave, spi request sink
	typedef struct packed {
		logic       mode_i2c;
		logic [7:0] page;
		logic [7:0] wire_cfg;
		logic [7:0] io_cfg;
		logic [7:0] rd;
		logic       ack_tgl;
		logic       req_seen;
		logic       pend;
		i2c_st_t    ist;
		i2c_st_t    after;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic       scl_prev;
		logic       sda_prev;
		logic       sda_oe;
		logic       sda_out;
	} core_t;

	// serial clock domain, survives chip select
	typedef struct packed {
		logic       addr_valid;
		logic [7:0] addr;
		logic       req_tgl;
		logic       req_wr;
		logic [7:0] req_waddr;
		logic [7:0] req_wdata;
		logic [7:0] req_faddr;
	} link_t;

	// serial clock domain, cleared by chip select high
	typedef struct packed {
		spi_st_t    st;
		logic [2:0] cnt;
		logic [7:0] sh;
		logic       inc;
		logic [7:0] tx;
		logic       dbit;
		logic       sdo_oe;
		logic       sdio_oe;
	} frame_t;

endpackage

/* File: bit_sync.sv */
// Purpose: two flip-flop synchroniser for a group of levels
// Assumes: each bit is an independent level or toggle
// Notes: no reset; outputs settle two edges after clocking starts
`timescale 1ns/10ps
module bit_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		meta_q <= d;
		q      <= meta_q;
	end
endmodule

/* File: dual_serial_config_port.sv */
// Purpose: i2c or spi slave access to the paged configuration registers
// Assumes: spi mode 0, sclk stops between commands, strap static in reset
// Notes: spi logic runs on sclk, registers live on clock, toggle handshake
//
// Functional notes
// - eight-bit addresses; page byte at low address 0x01 selects the page.
// - threshold bit is bit 0, resets to the core-supply option.
// - wire-count bit is bit 3, resets to 4-wire operation.
// - in 4-wire setting, writes from a 3-wire host still work.
// - i2c slave only, 7-bit addressing, standard and fast rates.
// - i2c address is fixed five bits plus two select pins.
// - i2c bytes are eight bits, most significant bit first.
// - i2c write is address, register pointer, data; bursts auto-increment.
// - i2c read follows a pointer write; read bursts auto-increment.
// - 3-wire merges data in and out onto one pin.
// - set-address, write and read commands decoded from top three bits.
// - increment commands move one byte then advance the address.
// - low five bits of don't-care commands are ignored.
// - burst write is command, start address, then any number of bytes.
// - burst address wraps from 255 to 0.
// - burst write ends only when chip select goes high.
// - there is no burst read command.
// - chip select high ends the current command.
// - stopped serial clock between commands loses no state.
`timescale 1ns/10ps
`include "dual_serial_config_port_params.svh"
module dual_serial_config_port (
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic i2c_select,
	input  wire logic sclk,
	input  wire logic chip_select_n,
	input  wire logic addr_select_pin1,
	input  wire logic sdio_in,
	output logic      sda_out,
	output logic      sda_oe,
	output logic      sdio_out,
	output logic      sdio_oe,
	output logic      sdo_out,
	output logic      sdo_oe,
	output logic      wire_count_select,
	output logic      io_threshold_select
);
	serial_port_pkg::core_t  c_q;
	serial_port_pkg::core_t  c_d;
	serial_port_pkg::link_t  l_q;
	serial_port_pkg::link_t  l_d;
	serial_port_pkg::frame_t f_q;
	serial_port_pkg::frame_t f_d;

	logic       s_strap;
	logic       s_scl;
	logic       s_sda;
	logic       s_a1;
	logic       s_a0;
	logic       s_req;
	logic       k_rst_b;
	logic       k_mode;
	logic       k_w3;
	logic       k_ack;
	logic       wen;
	logic [15:0] waddr;
	logic [7:0] wdata;
	logic       scl_r;
	logic       scl_f;
	logic       start;
	logic       stop;
	logic [7:0] rv;
	logic [7:0] nsh;
	logic [7:0] tx;
	logic       last;

	// pins and the spi request toggle into the core domain
	bit_sync #(.W(6)) core_sync (
		.clk (clock),
		.d   ({i2c_select, sclk, sdio_in, addr_select_pin1, chip_select_n, l_q.req_tgl}),
		.q   ({s_strap, s_scl, s_sda, s_a1, s_a0, s_req})
	);

	// reset, mode, wire count and fetch ack into the sclk domain
	bit_sync #(.W(4)) link_sync (
		.clk (sclk),
		.d   ({rst_b, c_q.mode_i2c, c_q.wire_cfg[`WIRE_SEL_BIT], c_q.ack_tgl}),
		.q   ({k_rst_b, k_mode, k_w3, k_ack})
	);

	// register read decode, shared by i2c reads and spi fetches
	function automatic logic [7:0] reg_read(input logic [15:0] a, input serial_port_pkg::core_t c);
		reg_read = 8'h00;
		if (a[7:0] == `PAGE_SEL_LOW) begin
			reg_read = c.page;
		end else if (a == `WIRE_CFG_OFS) begin
			reg_read = c.wire_cfg;
		end else if (a == `IO_CFG_OFS) begin
			reg_read = c.io_cfg;
		end
	endfunction

	// hand a write and/or fetch request over to the core domain
	function automatic serial_port_pkg::link_t issue(input serial_port_pkg::link_t l, input logic wr,
		input logic [7:0] wd, input logic [7:0] fa);
		issue           = l;
		issue.req_tgl   = ~l.req_tgl;
		issue.req_wr    = wr;
		issue.req_waddr = l.addr;
		issue.req_wdata = wd;
		issue.req_faddr = fa;
		issue.addr      = fa;
		issue.addr_valid = 1'b1;
	endfunction

	// core domain: register file, spi request sink, i2c slave
	always_comb begin
		c_d   = c_q;
		wen   = 1'b0;
		waddr = 16'h0000;
		wdata = 8'h00;
		rv    = reg_read({c_q.page, c_q.ptr}, c_q);
		scl_r = s_scl & ~c_q.scl_prev;
		scl_f = ~s_scl & c_q.scl_prev;
		start = s_scl & c_q.scl_prev & c_q.sda_prev & ~s_sda;
		stop  = s_scl & c_q.scl_prev & ~c_q.sda_prev & s_sda;
		c_d.scl_prev = s_scl;
		c_d.sda_prev = s_sda;
		if (!c_q.mode_i2c) begin
			// spi requests: write first, fetch one cycle later so it sees the write
			c_d.sda_oe = 1'b0;
			c_d.ist    = serial_port_pkg::I2C_IDLE;
			if (s_req != c_q.req_seen) begin
				c_d.req_seen = s_req;
				c_d.pend     = 1'b1;
				wen          = l_q.req_wr;
				waddr        = {c_q.page, l_q.req_waddr};
				wdata        = l_q.req_wdata;
			end
			if (c_q.pend) begin
				c_d.rd      = reg_read({c_q.page, l_q.req_faddr}, c_q);
				c_d.ack_tgl = c_q.req_seen;
				c_d.pend    = 1'b0;
			end
		end else if (start) begin
			// repeated start is accepted anywhere
			c_d.ist    = serial_port_pkg::I2C_ADDR;
			c_d.cnt    = 4'h0;
			c_d.sda_oe = 1'b0;
		end else if (stop) begin
			c_d.ist    = serial_port_pkg::I2C_IDLE;
			c_d.sda_oe = 1'b0;
		end else if (scl_r) begin
			case (c_q.ist)
				serial_port_pkg::I2C_ADDR, serial_port_pkg::I2C_REG, serial_port_pkg::I2C_WR: begin
					c_d.sh  = {c_q.sh[6:0], s_sda};
					c_d.cnt = c_q.cnt + 4'h1;
				end
				serial_port_pkg::I2C_MACK: begin
					// master nack ends the read burst
					if (s_sda) begin
						c_d.ist = serial_port_pkg::I2C_IDLE;
					end else begin
						c_d.ist   = serial_port_pkg::I2C_ACK;
						c_d.after = serial_port_pkg::I2C_RD;
					end
				end
				default: begin
				end
			endcase
		end else if (scl_f) begin
			case (c_q.ist)
				serial_port_pkg::I2C_ADDR: begin
					if (c_q.cnt == `I2C_BYTE_BITS) begin
						c_d.cnt = 4'h0;
						if (c_q.sh[7:1] == {`I2C_ADDR_HI, s_a1, s_a0}) begin
							c_d.sda_oe = 1'b1;
							c_d.ist    = serial_port_pkg::I2C_ACK;
							c_d.after  = c_q.sh[0] ? serial_port_pkg::I2C_RD : serial_port_pkg::I2C_REG;
						end else begin
							c_d.ist = serial_port_pkg::I2C_IDLE;
						end
					end
				end
				serial_port_pkg::I2C_REG: begin
					if (c_q.cnt == `I2C_BYTE_BITS) begin
						c_d.cnt    = 4'h0;
						c_d.ptr    = c_q.sh;
						c_d.sda_oe = 1'b1;
						c_d.ist    = serial_port_pkg::I2C_ACK;
						c_d.after  = serial_port_pkg::I2C_WR;
					end
				end
				serial_port_pkg::I2C_WR: begin
					if (c_q.cnt == `I2C_BYTE_BITS) begin
						wen        = 1'b1;
						waddr      = {c_q.page, c_q.ptr};
						wdata      = c_q.sh;
						c_d.ptr    = c_q.ptr + 8'h01;
						c_d.cnt    = 4'h0;
						c_d.sda_oe = 1'b1;
						c_d.ist    = serial_port_pkg::I2C_ACK;
						c_d.after  = serial_port_pkg::I2C_WR;
					end
				end
				serial_port_pkg::I2C_ACK: begin
					// ack slot over: release, or load the first bit of a read byte
					c_d.sda_oe = 1'b0;
					c_d.cnt    = 4'h0;
					c_d.ist    = c_q.after;
					if (c_q.after == serial_port_pkg::I2C_RD) begin
						c_d.sh     = rv;
						c_d.ptr    = c_q.ptr + 8'h01;
						c_d.sda_oe = ~rv[7];
						c_d.cnt    = 4'h1;
					end
				end
				serial_port_pkg::I2C_RD: begin
					if (c_q.cnt == `I2C_BYTE_BITS) begin
						c_d.sda_oe = 1'b0;
						c_d.ist    = serial_port_pkg::I2C_MACK;
					end else begin
						c_d.sh     = {c_q.sh[6:0], 1'b0};
						c_d.sda_oe = ~c_q.sh[6];
						c_d.cnt    = c_q.cnt + 4'h1;
					end
				end
				default: begin
				end
			endcase
		end
		// single write port into the register file
		if (wen) begin
			if (waddr[7:0] == `PAGE_SEL_LOW) begin
				c_d.page = wdata;
			end else if (waddr == `WIRE_CFG_OFS) begin
				c_d.wire_cfg = wdata;
			end else if (waddr == `IO_CFG_OFS) begin
				c_d.io_cfg = wdata;
			end
		end
	end

	// core registers; strap caught while reset is held
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			c_q          <= '{ist: serial_port_pkg::I2C_IDLE, after: serial_port_pkg::I2C_IDLE, default: '0};
			c_q.page     <= `PAGE_SEL_RST;
			c_q.wire_cfg <= `WIRE_CFG_RST;
			c_q.io_cfg   <= `IO_CFG_RST;
			c_q.mode_i2c <= s_strap;
			c_q.scl_prev <= 1'b1;
			c_q.sda_prev <= 1'b1;
		end else begin
			c_q <= c_d;
		end
	end

	// sclk domain: spi command decoder
	always_comb begin
		l_d  = l_q;
		f_d  = f_q;
		nsh  = {f_q.sh[6:0], sdio_in};
		last = (f_q.cnt == 3'h7);
		tx   = (k_ack == l_q.req_tgl) ? c_q.rd : `RD_NOT_READY;
		f_d.cnt = f_q.cnt + 3'h1;
		f_d.sh  = nsh;
		case (f_q.st)
			serial_port_pkg::SPI_CMD: begin
				if (last) begin
					f_d.st = serial_port_pkg::SPI_SKIP;
					case (nsh[7:5])
						`CMD_SET_ADDR: begin
							f_d.st = serial_port_pkg::SPI_ADDR;
						end
						`CMD_WR, `CMD_WR_INC: begin
							f_d.st  = serial_port_pkg::SPI_WDATA;
							f_d.inc = nsh[5];
						end
						`CMD_RD, `CMD_RD_INC: begin
							// first bit launched now, sampled by the host on the next rise
							f_d.st      = serial_port_pkg::SPI_RDATA;
							f_d.inc     = nsh[5];
							f_d.dbit    = tx[7];
							f_d.tx      = {tx[6:0], 1'b0};
							f_d.sdo_oe  = ~k_w3 & ~k_mode;
							f_d.sdio_oe = k_w3 & ~k_mode;
						end
						default: begin
							if (nsh == `CMD_BURST) begin
								f_d.st = serial_port_pkg::SPI_BADDR;
							end
						end
					endcase
				end
			end
			serial_port_pkg::SPI_ADDR: begin
				if (last) begin
					f_d.st = serial_port_pkg::SPI_SKIP;
					if (!k_mode) begin
						l_d = issue(l_q, 1'b0, 8'h00, nsh);
					end
				end
			end
			serial_port_pkg::SPI_WDATA: begin
				if (last) begin
					f_d.st = serial_port_pkg::SPI_SKIP;
					if (!k_mode) begin
						l_d = issue(l_q, 1'b1, nsh, l_q.addr + {7'h00, f_q.inc});
					end
				end
			end
			serial_port_pkg::SPI_RDATA: begin
				if (last) begin
					f_d.st      = serial_port_pkg::SPI_SKIP;
					f_d.sdo_oe  = 1'b0;
					f_d.sdio_oe = 1'b0;
					if (!k_mode && f_q.inc) begin
						l_d = issue(l_q, 1'b0, 8'h00, l_q.addr + 8'h01);
					end
				end else begin
					f_d.dbit = f_q.tx[7];
					f_d.tx   = {f_q.tx[6:0], 1'b0};
				end
			end
			serial_port_pkg::SPI_BADDR: begin
				if (last) begin
					f_d.st     = serial_port_pkg::SPI_BDATA;
					l_d.addr   = nsh;
				end
			end
			serial_port_pkg::SPI_BDATA: begin
				// stays here until chip select rises; address wraps at 8 bits
				if (last && !k_mode) begin
					l_d = issue(l_q, 1'b1, nsh, l_q.addr + 8'h01);
				end
			end
			serial_port_pkg::SPI_SKIP: begin
				f_d.cnt = f_q.cnt;
			end
			default: begin
				f_d.st = serial_port_pkg::SPI_SKIP;
			end
		endcase
	end

	// frame state ends with chip select; sclk may never tick again
	always_ff @(posedge sclk or posedge chip_select_n) begin
		if (chip_select_n) begin
			f_q <= '{st: serial_port_pkg::SPI_CMD, default: '0};
		end else begin
			f_q <= f_d;
		end
	end

	// address and handshake outlive the frame, so idle sclk loses nothing
	always_ff @(posedge sclk) begin
		if (!k_rst_b) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	// outputs straight from flops
	assign sda_out             = c_q.sda_out;
	assign sda_oe              = c_q.sda_oe;
	assign sdio_out            = f_q.dbit;
	assign sdio_oe             = f_q.sdio_oe;
	assign sdo_out             = f_q.dbit;
	assign sdo_oe              = f_q.sdo_oe;
	assign wire_count_select   = c_q.wire_cfg[`WIRE_SEL_BIT];
	assign io_threshold_select = c_q.io_cfg[`IO_SEL_BIT];
endmodule

/* File: dual_serial_config_port_sva.sv */
// Purpose: port-level checks for the dual serial configuration port
// Assumes: spi mode 0, chip select high clears the frame logic
// Notes: sclk-side checks are switched off while chip select is high
`timescale 1ns/10ps
module dual_serial_config_port_sva (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic i2c_select,
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic addr_select_pin1,
	input wire logic sdio_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic sdio_out,
	input wire logic sdio_oe,
	input wire logic sdo_out,
	input wire logic sdo_oe,
	input wire logic wire_count_select,
	input wire logic io_threshold_select
);
	logic       rd_oe;
	logic [7:0] rise_q;
	// read drive on either data pin
	assign rd_oe = sdo_oe | sdio_oe;
	// sclk rises in this frame; saturates so long bursts cannot wrap it
	always_ff @(posedge sclk or posedge chip_select_n) begin
		if (chip_select_n) begin
			rise_q <= 8'h00;
		end else if (rise_q != 8'hff) begin
			rise_q <= rise_q + 8'h01;
		end
	end
	sequence s_read_byte;
		rd_oe [*8];
	endsequence
	a_reset_values: assert property (@(posedge clock) disable iff (!rst_b) $rose(rst_b) |-> !wire_count_select && !io_threshold_select && !sda_oe)
		else $error("config outputs not cleared by reset");
	a_cs_idle_quiet: assert property (@(posedge clock) disable iff (!rst_b) chip_select_n |-> !rd_oe)
		else $error("read drive while chip select high");
	a_one_data_pin: assert property (@(posedge clock) disable iff (!rst_b) !(sdo_oe && sdio_oe))
		else $error("both data pins driven");
	a_three_wire_pin: assert property (@(posedge clock) disable iff (!rst_b) sdio_oe |-> wire_count_select)
		else $error("shared pin driven in 4-wire setting");
	a_four_wire_pin: assert property (@(posedge clock) disable iff (!rst_b) sdo_oe |-> !wire_count_select)
		else $error("output pin driven in 3-wire setting");
	a_i2c_spi_off: assert property (@(posedge clock) disable iff (!rst_b) i2c_select |-> !rd_oe)
		else $error("spi read drive in i2c mode");
	a_spi_sda_off: assert property (@(posedge clock) disable iff (!rst_b) !i2c_select |-> !sda_oe)
		else $error("i2c data pulled in spi mode");
	a_read_full_byte: assert property (@(posedge sclk) disable iff (chip_select_n) $rose(rd_oe) |-> s_read_byte)
		else $error("read drive shorter than a byte");
	a_read_at_byte: assert property (@(posedge sclk) disable iff (chip_select_n) rd_oe |-> rise_q >= 8'h08 && rise_q <= 8'h0f)
		else $error("read drive outside the byte after the command");
endmodule
bind dual_serial_config_port dual_serial_config_port_sva u_sva (
	.clock, .rst_b, .i2c_select, .sclk, .chip_select_n, .addr_select_pin1, .sdio_in, .sda_out,
	.sda_oe, .sdio_out, .sdio_oe, .sdo_out, .sdo_oe, .wire_count_select, .io_threshold_select
);

/* File: spi_host_model.sv */
// Purpose: spi master at the far side of the configuration port
// Assumes: mode 0, 48 ns serial clock, msb first
// Notes: sclk stands still outside frames except in idle_clocks and the i2c tasks; released lines keep moving
`timescale 1ns/10ps
module spi_host_model (
	output logic      sclk,
	output logic      chip_select_n,
	output logic      sdio_in,
	input  wire logic sdio_out,
	input  wire logic sdio_oe,
	input  wire logic sdo_out,
	input  wire logic sdo_oe,
	input  wire logic sda_oe
);
	logic host_oe = 1'b1;
	logic host_bit = 1'b0;
	logic sdio_last = 1'b0;
	logic sdo_last = 1'b0;
	logic sdo_line;
	// device drive wins; a released line never holds its old level
	assign sdio_in = sdio_oe ? sdio_out : (sda_oe ? 1'b0 : (host_oe ? host_bit : ~sdio_last));
	assign sdo_line = sdo_oe ? sdo_out : ~sdo_last;
	always @(posedge sclk) begin
		sdio_last <= sdio_in;
		sdo_last <= sdo_line;
	end
	initial begin
		sclk = 1'b0;
		chip_select_n = 1'b1;
	end
	// edges with chip select high, so the link side sees its reset
	task automatic idle_clocks();
		repeat (4) begin
			#24 sclk = 1'b1;
			#24 sclk = 1'b0;
		end
	endtask
	task automatic cs_open();
		#31 chip_select_n = 1'b0;
		#30;
	endtask
	// chip select high ends the command; gap kept well over the minimum
	task automatic cs_close();
		#30 chip_select_n = 1'b1;
		host_oe = 1'b1;
		#110;
	endtask
	// rel frees the shared pin so a 3-wire read can come back
	task automatic xbyte(input logic [7:0] tx, input logic rel, input logic three, output logic [7:0] rx,
		output logic seen);
		seen = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			host_oe = ~rel;
			host_bit = tx[i];
			#24;
			rx[i] = three ? sdio_in : sdo_line;
			seen = seen | sdo_oe | sdio_oe;
			sclk = 1'b1;
			#24 sclk = 1'b0;
		end
	endtask
	// i2c master on the same pins; data moves only while scl is low, so only start and stop edges occur
	task automatic i2c_start();
		host_oe = 1'b1;
		host_bit = 1'b1;
		#100 sclk = 1'b1;
		#100 host_bit = 1'b0;
		#100 sclk = 1'b0;
	endtask
	// ninth bit left high as the pull-up would hold it; the slave's pull wins
	task automatic i2c_byte(input logic [7:0] b, output logic ack);
		logic [8:0] w;
		w = {b, 1'b1};
		for (int i = 8; i >= 0; i--) begin
			host_bit = w[i];
			#100 sclk = 1'b1;
			ack = sdio_in;
			#100 sclk = 1'b0;
		end
	endtask
	task automatic i2c_stop();
		host_bit = 1'b0;
		#100 sclk = 1'b1;
		#100 host_bit = 1'b1;
		#100;
	endtask
endmodule

/* File: dual_serial_config_port_tb.sv */
// Purpose: self-checking bench for the dual serial configuration port
// Assumes: spi slave mode except in the strap test
// Notes: i2c covered by one addressed write; the i2c read path is not exercised
`timescale 1ns/10ps
`include "dual_serial_config_port_params.svh"
module dual_serial_config_port_tb;
	typedef struct packed {
		logic [7:0] page;
		logic [7:0] addr;
		logic [7:0] wcmd;
		logic [7:0] data;
		logic [7:0] rcmd;
		logic [7:0] exp;
		logic       wcs;
		logic       io;
	} row_t;
	row_t       rows [5] = '{'{8'h00, 8'h2b, 8'h40, 8'h08, 8'h80, 8'h08, 1'b1, 1'b0},
		'{8'h09, 8'h43, 8'h5f, 8'h01, 8'h9f, 8'h01, 1'b1, 1'b1}, '{8'h09, 8'h44, 8'h60, 8'ha5, 8'ha0, 8'h00, 1'b1, 1'b1},
		'{8'h09, 8'h01, 8'h40, 8'h09, 8'h80, 8'h09, 1'b1, 1'b1}, '{8'h00, 8'h2b, 8'h7f, 8'h00, 8'hbf, 8'h00, 1'b0, 1'b1}};
	logic [7:0] burst [5] = '{8'he0, 8'hff, 8'haa, 8'haa, 8'h09};
	// address pin 0 is the idle-high chip select, pin 1 is low; then pointer and data
	logic [7:0] i2c_wr [3] = '{{`I2C_ADDR_HI, 1'b0, 1'b1, 1'b0}, 8'h2b, 8'h08};
	logic       clock = 1'b0;
	logic       rst_b = 1'b0;
	logic       i2c_select = 1'b0;
	logic       addr_select_pin1 = 1'b0;
	logic       three = 1'b0;
	logic       seen;
	logic [7:0] rx;
	int         n_errors = 0;
	int         total_checks = 0;
	int         cycles = 0;
	wire        sclk, chip_select_n, sdio_in, sda_out, sda_oe, sdio_out, sdio_oe;
	wire        sdo_out, sdo_oe, wire_count_select, io_threshold_select;
	dual_serial_config_port u_dual_serial_config_port (
		.clock, .rst_b, .i2c_select, .sclk, .chip_select_n, .addr_select_pin1, .sdio_in, .sda_out,
		.sda_oe, .sdio_out, .sdio_oe, .sdo_out, .sdo_oe, .wire_count_select, .io_threshold_select
	);
	spi_host_model u_spi_host_model (
		.sclk, .chip_select_n, .sdio_in, .sdio_out, .sdio_oe, .sdo_out, .sdo_oe, .sda_oe
	);
	always #4 clock = ~clock;
	// cut a hang short; the sequence needs a little under half of this
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors = n_errors + 1;
			wrap_up();
		end
	end
	task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// strap only moves while reset is low, as the port requires
	task automatic reset_dut(input logic sel);
		@(negedge clock);
		rst_b = 1'b0;
		i2c_select = sel;
		u_spi_host_model.idle_clocks();
		repeat (8) @(negedge clock);
		rst_b = 1'b1;
		repeat (4) @(negedge clock);
	endtask
	task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic rd);
		logic [7:0] dummy;
		logic       s;
		u_spi_host_model.cs_open();
		u_spi_host_model.xbyte(b0, 1'b0, three, dummy, s);
		u_spi_host_model.xbyte(b1, rd & three, three, rx, seen);
		u_spi_host_model.cs_close();
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] cmd, input logic [7:0] d);
		frame(8'h00, a, 1'b0);
		frame(cmd, d, 1'b0);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] cmd);
		frame(8'h00, a, 1'b0);
		frame(cmd, 8'h00, 1'b1);
	endtask
	initial begin
		reset_dut(1'b0);
		chk("wire_count_select", {7'h00, wire_count_select}, 8'h00);
		chk("io_threshold_select", {7'h00, io_threshold_select}, 8'h00);
		chk("sda_out", {7'h00, sda_out}, 8'h00);
		rreg(8'h01, 8'h80);
		chk("page_select", rx, 8'h00);
		rreg(8'h2b, 8'h80);
		chk("spi_wire_config", rx, 8'h00);
		$display("reset test done");
		// ordinary accesses: page, address, write, read back
		foreach (rows[r]) begin
			wreg(8'h01, 8'h40, rows[r].page);
			wreg(rows[r].addr, rows[r].wcmd, rows[r].data);
			// once the wire-count bit is set, reads come back on the shared pin only
			three = rows[r].wcs;
			rreg(rows[r].addr, rows[r].rcmd);
			chk("read data", rx, rows[r].exp);
			chk("wire_count_select", {7'h00, wire_count_select}, {7'h00, rows[r].wcs});
			chk("io_threshold_select", {7'h00, io_threshold_select}, {7'h00, rows[r].io});
			$display("row %0d done", r);
		end
		// increments use the named address; the next access lands one higher
		frame(8'h00, 8'h2a, 1'b0);
		frame(8'h60, 8'h77, 1'b0);
		frame(8'h40, 8'h08, 1'b0);
		chk("inc write", {7'h00, wire_count_select}, 8'h01);
		three = 1'b1;
		frame(8'h00, 8'h2a, 1'b0);
		frame(8'ha0, 8'h00, 1'b1);
		frame(8'h80, 8'h00, 1'b1);
		chk("inc read", rx, 8'h08);
		$display("increment test done");
		// undefined codes: no write and no read drive
		frame(8'h00, 8'h2b, 1'b0);
		frame(8'h20, 8'h00, 1'b0);
		frame(8'hc0, 8'h00, 1'b1);
		chk("refused read drive", {7'h00, seen}, 8'h00);
		chk("refused write", {7'h00, wire_count_select}, 8'h01);
		$display("refusal test done");
		// 3-wire host: read back on the shared pin, writes in 4-wire setting
		three = 1'b1;
		rreg(8'h2b, 8'h80);
		chk("three-wire read", rx, 8'h08);
		wreg(8'h2b, 8'h40, 8'h00);
		wreg(8'h2b, 8'h40, 8'h08);
		chk("three-wire write", {7'h00, wire_count_select}, 8'h01);
		$display("three-wire test done");
		// burst across the top of the address range into the page byte
		u_spi_host_model.cs_open();
		foreach (burst[i]) begin
			u_spi_host_model.xbyte(burst[i], 1'b0, 1'b0, rx, seen);
		end
		u_spi_host_model.cs_close();
		rreg(8'h01, 8'h80);
		chk("burst wrap", rx, 8'h09);
		#5000;
		rreg(8'h43, 8'h80);
		chk("after idle", rx, 8'h01);
		$display("burst and idle test done");
		// i2c strap: spi traffic must leave the registers alone
		reset_dut(1'b1);
		chk("reset wire", {7'h00, wire_count_select}, 8'h00);
		wreg(8'h2b, 8'h40, 8'h08);
		chk("i2c strap", {7'h00, wire_count_select}, 8'h00);
		// one i2c write of the wire-count byte: address, pointer, data, each acknowledged
		u_spi_host_model.i2c_start();
		foreach (i2c_wr[i]) begin
			u_spi_host_model.i2c_byte(i2c_wr[i], seen);
			chk("i2c ack", {7'h00, seen}, 8'h00);
		end
		u_spi_host_model.i2c_stop();
		chk("i2c write", {7'h00, wire_count_select}, 8'h01);
		$display("strap test done");
		wrap_up();
	end
endmodule
